// ### logic/pax_params.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Register index times four gives the Avalon byte address
// Notes: Included by the design files
`ifndef PAX_PARAMS_SVH
`define PAX_PARAMS_SVH

`define PAX_IDX_ANEXP 6'h06
`define PAX_IDX_CFG 6'h10

`define PAX_ANEXP_PFAULT 4
`define PAX_ANEXP_LPNP 3
`define PAX_ANEXP_LNP 2
`define PAX_ANEXP_PRX 1
`define PAX_ANEXP_LPAN 0

`define PAX_CFG_SMR 3
`define PAX_CFG_RESET 16'h0414
`define PAX_CFG_WMASK 16'hfdf7

`define PAX_CLK_PERIOD_NS 10
`define PAX_SMR_TIME_NS 200
`define PAX_SMR_CYCLES ((`PAX_SMR_TIME_NS + `PAX_CLK_PERIOD_NS - 1) / `PAX_CLK_PERIOD_NS)

`endif

// ### logic/pax_pkg.sv
// Purpose: Types shared by the register bank and its sequencer
// Assumes: Nothing
// Notes: First struct member is the most significant bit
package pax_pkg;

    typedef enum logic {PAX_BUS_IDLE, PAX_BUS_DONE} pax_bus_state_type;

    typedef enum logic {PAX_SMR_IDLE, PAX_SMR_RUN} pax_smr_state_type;

    typedef struct packed {
        logic parDetectFault;
        logic partnerNextPage;
        logic pageReceived;
        logic partnerAutoneg;
        logic signalDetector;
        logic lineLink100;
    } pax_an_status_type;

    typedef struct packed {
        logic codecBypass;
        logic scrambleBypass;
        logic alignBypass;
        logic signalDetectOk;
        logic mediaModeTx;
        logic linkGood100;
        logic autoPowerDown;
        logic preambleSuppress;
        logic sleepMode;
        logic remoteLoopOut;
        logic stateMachineReset;
    } pax_dp_ctl_type;

    typedef struct packed {
        logic codingBypass;
        logic scramblerBypass;
        logic alignmentBypass;
        logic signalDetectOverride;
        logic rsvd11;
        logic mediaModeSelect;
        logic rsvd9;
        logic rsvd8;
        logic forcedLink;
        logic speedLedReserved;
        logic collisionLedReserved;
        logic reducedPowerEnable;
        logic stateMachineReset;
        logic mgmtPreambleSuppress;
        logic sleepMode;
        logic remoteLoopOut;
    } pax_cfg_type;

endpackage

// ### logic/pax_sm_reset.sv
// Purpose: Holds the PHY state machine reset for a fixed time
// Assumes: start is a one-cycle pulse
// Notes: A start while running restarts the count
`timescale 1ns/10ps
`include "pax_params.svh"

module pax_sm_reset #(
    parameter int CYCLES = `PAX_SMR_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    output logic busy
);
    import pax_pkg::*;

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    pax_smr_state_type state_q, state_d;
    logic [CW-1:0] count_q, count_d;
    logic busy_q, busy_d;

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            PAX_SMR_IDLE: begin
                if (start) begin
                    state_d = PAX_SMR_RUN;
                    count_d = '0;
                end
            end
            PAX_SMR_RUN: begin
                if (start) begin
                    count_d = '0;
                end else if (count_q == LAST) begin
                    state_d = PAX_SMR_IDLE;
                end else begin
                    count_d = count_q + CW'(1);
                end
            end
            default: begin
                state_d = PAX_SMR_IDLE;
            end
        endcase
        busy_d = (state_d == PAX_SMR_RUN);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= PAX_SMR_IDLE;
            count_q <= '0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            busy_q <= busy_d;
        end
    end

    assign busy = busy_q;
endmodule

// ### logic/pax_regs.sv
// Purpose: Expansion and vendor configuration registers on Avalon-MM
// Assumes: Status inputs synchronous to clk; byte addressing on the bus
// Notes: Each access answers with waitrequest low one cycle after it is seen
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "pax_params.svh"

module pax_regs #(
    parameter int ADDR_W = 8,
    parameter int SMR_CYCLES = `PAX_SMR_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire pax_pkg::pax_an_status_type anStatus,
    output pax_pkg::pax_dp_ctl_type dpCtl
);
    import pax_pkg::*;

    // Word index hit for a register
    function automatic logic hitIndex(input logic [ADDR_W-1:0] addr,
                                      input logic [5:0] idx);
        logic [ADDR_W-1:0] wide;
        wide = {{(ADDR_W-6){1'b0}}, idx};
        hitIndex = (addr[ADDR_W-1:2] == wide[ADDR_W-3:0]);
    endfunction

    // Byte lane merge of a 16-bit register
    function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                               input logic [15:0] data,
                                               input logic [1:0] be);
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = data[7:0];
        end
        if (be[1]) begin
            res[15:8] = data[15:8];
        end
        mergeLanes = res;
    endfunction

    // Bus handshake state
    pax_bus_state_type busState_q, busState_d;
    logic waitReq_q, waitReq_d;
    logic [31:0] readData_q, readData_d;

    // Latched status
    logic parFault_q, parFault_d;
    logic pageRx_q, pageRx_d;

    // Configuration storage
    pax_cfg_type cfg_q, cfg_d;
    logic sleepPrev_q, sleepPrev_d;

    // Datapath controls
    pax_dp_ctl_type dp_q, dp_d;

    // Decoded access
    logic accept;
    logic hitAnexp;
    logic hitCfg;
    logic readAnexp;
    logic writeCfg;
    logic smrStart;
    logic smrBusy;
    logic wake;
    logic [15:0] anexpView;
    logic [15:0] cfgView;
    logic [15:0] cfgMerged;

    assign accept = (busState_q == PAX_BUS_IDLE) && (avs_read || avs_write);
    assign hitAnexp = hitIndex(avs_address, `PAX_IDX_ANEXP);
    assign hitCfg = hitIndex(avs_address, `PAX_IDX_CFG);
    assign readAnexp = accept && avs_read && hitAnexp;
    assign writeCfg = accept && avs_write && hitCfg;

    // Expansion view; upper bits and local next page fixed at zero
    always_comb begin
        anexpView = 16'h0000;
        anexpView[`PAX_ANEXP_PFAULT] = parFault_q;
        anexpView[`PAX_ANEXP_LPNP] = anStatus.partnerNextPage;
        anexpView[`PAX_ANEXP_LNP] = 1'b0;
        anexpView[`PAX_ANEXP_PRX] = pageRx_q;
        anexpView[`PAX_ANEXP_LPAN] = anStatus.partnerAutoneg;
    end

    // Config view; the reset bit reads back the live sequencer
    always_comb begin
        cfgView = cfg_q;
        cfgView[`PAX_CFG_SMR] = smrBusy;
    end

    assign cfgMerged = mergeLanes(cfg_q, avs_writedata[15:0], avs_byteenable[1:0]);

    // Bus handshake
    always_comb begin
        busState_d = busState_q;
        waitReq_d = waitReq_q;
        readData_d = readData_q;
        case (busState_q)
            PAX_BUS_IDLE: begin
                waitReq_d = 1'b1;
                if (avs_read || avs_write) begin
                    busState_d = PAX_BUS_DONE;
                    waitReq_d = 1'b0;
                    if (avs_read) begin
                        if (hitAnexp) begin
                            readData_d = {16'h0000, anexpView};
                        end else if (hitCfg) begin
                            readData_d = {16'h0000, cfgView};
                        end else begin
                            readData_d = 32'h0000_0000;
                        end
                    end
                end
            end
            PAX_BUS_DONE: begin
                busState_d = PAX_BUS_IDLE;
                waitReq_d = 1'b1;
            end
            default: begin
                busState_d = PAX_BUS_IDLE;
                waitReq_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busState_q <= PAX_BUS_IDLE;
            waitReq_q <= 1'b1;
            readData_q <= 32'h0000_0000;
        end else begin
            busState_q <= busState_d;
            waitReq_q <= waitReq_d;
            readData_q <= readData_d;
        end
    end

    // Latched status; a new event beats the read clear
    always_comb begin
        parFault_d = anStatus.parDetectFault | parFault_q;
        if (readAnexp) begin
            parFault_d = anStatus.parDetectFault;
        end
        pageRx_d = anStatus.pageReceived | pageRx_q;
        if (readAnexp) begin
            pageRx_d = anStatus.pageReceived;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            parFault_q <= 1'b0;
            pageRx_q <= 1'b0;
        end else begin
            parFault_q <= parFault_d;
            pageRx_q <= pageRx_d;
        end
    end

    // Configuration writes
    always_comb begin
        cfg_d = cfg_q;
        smrStart = 1'b0;
        if (writeCfg) begin
            cfg_d = cfgMerged & `PAX_CFG_WMASK;
            smrStart = avs_byteenable[0] && avs_writedata[`PAX_CFG_SMR];
        end
        sleepPrev_d = cfg_q.sleepMode;
    end

    // Leaving sleep restarts the state machines, config is kept
    assign wake = sleepPrev_q && !cfg_q.sleepMode;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_q <= `PAX_CFG_RESET;
            sleepPrev_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            sleepPrev_q <= sleepPrev_d;
        end
    end

    pax_sm_reset #(
        .CYCLES(SMR_CYCLES)
    ) u_sm_reset (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(smrStart || wake),
        .busy(smrBusy)
    );

    // Datapath controls
    always_comb begin
        dp_d.codecBypass = cfg_q.codingBypass | cfg_q.alignmentBypass;
        dp_d.scrambleBypass = cfg_q.scramblerBypass | cfg_q.alignmentBypass;
        dp_d.alignBypass = cfg_q.alignmentBypass;
        dp_d.signalDetectOk = anStatus.signalDetector | cfg_q.signalDetectOverride;
        dp_d.mediaModeTx = cfg_q.mediaModeSelect;
        dp_d.linkGood100 = anStatus.lineLink100 | cfg_q.forcedLink;
        dp_d.autoPowerDown = cfg_q.reducedPowerEnable;
        dp_d.preambleSuppress = cfg_q.mgmtPreambleSuppress;
        dp_d.sleepMode = cfg_q.sleepMode;
        dp_d.remoteLoopOut = cfg_q.remoteLoopOut;
        dp_d.stateMachineReset = smrBusy;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dp_q <= '0;
        end else begin
            dp_q <= dp_d;
        end
    end

    assign avs_readdata = readData_q;
    assign avs_waitrequest = waitReq_q;
    assign dpCtl = dp_q;
endmodule

// ### verif/pax_regs_sva.sv
// Purpose: Port checks of the expansion and config registers
// Assumes: Byte address is register index times four
// Notes: Latch helpers track events between reads
`timescale 1ns/10ps
module pax_regs_sva #(
    parameter int ADDR_W = 8,
    parameter int SMR_CYCLES = 20
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire pax_pkg::pax_an_status_type anStatus,
    input wire pax_pkg::pax_dp_ctl_type dpCtl
);
    import pax_pkg::*;
    logic rdExp;
    logic rdCfg;
    logic wrSmr;
    logic page_q;
    logic fault_q;
    int run_q;
    assign rdExp = avs_read && avs_waitrequest && (avs_address >> 2) == 'h06;
    assign rdCfg = avs_read && avs_waitrequest && (avs_address >> 2) == 'h10;
    assign wrSmr = avs_write && avs_waitrequest && (avs_address >> 2) == 'h10
        && avs_byteenable[0] && avs_writedata[3];
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            page_q <= 1'b0;
            fault_q <= 1'b0;
            run_q <= 0;
        end else begin
            page_q <= anStatus.pageReceived || (page_q && !rdExp);
            fault_q <= anStatus.parDetectFault || (fault_q && !rdExp);
            run_q <= dpCtl.stateMachineReset ? run_q + 1 : 0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    exp_rsvd_a: assert property (rdExp |=> avs_readdata[15:5] == 11'h000 && !avs_readdata[2])
        else $error("expansion reserved bits not zero");
    page_latch_a: assert property (rdExp |=> avs_readdata[1] == $past(page_q))
        else $error("page received flag wrong");
    fault_latch_a: assert property (rdExp |=> avs_readdata[4] == $past(fault_q))
        else $error("fault flag wrong");
    partner_live_a: assert property (rdExp |=> avs_readdata[3] == $past(anStatus.partnerNextPage)
        && avs_readdata[0] == $past(anStatus.partnerAutoneg)) else $error("partner flags wrong");
    cfg_rsvd_a: assert property (rdCfg |=> !avs_readdata[9])
        else $error("config bit 9 not zero");
    detect_force_a: assert property ($past(anStatus.signalDetector) |-> dpCtl.signalDetectOk)
        else $error("signal detect lost");
    link_force_a: assert property ($past(anStatus.lineLink100) |-> dpCtl.linkGood100)
        else $error("line link lost");
    bypass_tie_a: assert property (dpCtl.alignBypass |-> dpCtl.codecBypass && dpCtl.scrambleBypass)
        else $error("alignment bypass incomplete");
    smr_start_a: assert property (wrSmr |-> ##[1:3] dpCtl.stateMachineReset)
        else $error("state reset not started");
    smr_span_a: assert property ($fell(dpCtl.stateMachineReset) |-> run_q >= SMR_CYCLES)
        else $error("state reset too short");
    wake_keep_a: assert property ($fell(dpCtl.sleepMode) |-> $stable({dpCtl.mediaModeTx,
        dpCtl.remoteLoopOut}) ##[0:2] dpCtl.stateMachineReset) else $error("wake wrong");
    cover property (rdExp ##1 avs_readdata[1]);
    cover property (wrSmr);
    cover property ($fell(dpCtl.sleepMode));
endmodule
bind pax_regs pax_regs_sva #(.ADDR_W(ADDR_W), .SMR_CYCLES(SMR_CYCLES)) u_pax_regs_sva (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .anStatus(anStatus),
    .dpCtl(dpCtl));

// ### verif/pax_mgmt_model.sv
// Purpose: Management master issuing register cycles
// Assumes: Slave answers by dropping waitrequest
// Notes: Released address and write data show inverted last values
`timescale 1ns/10ps
module pax_mgmt_model (
    input wire logic clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable
);
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
    end
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d,
        input logic [1:0] be, output logic [15:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {16'h0000, a == 8'h40 ? d & 16'hf69f : d};
        avs_byteenable <= {2'b00, be};
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~avs_writedata;
    endtask
endmodule

// ### verif/pax_regs_tb_top.sv
// Purpose: Self-checking bench for the expansion and config registers
// Assumes: Sequencer shortened to eight cycles
// Notes: Integer model predicts every read and control output
`timescale 1ns/10ps
`include "pax_params.svh"
module pax_regs_tb_top;
    import pax_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    pax_an_status_type anStatus = '0;
    pax_dp_ctl_type dpCtl;
    int num_errors = 0;
    int cmp_count = 0;
    int seed = 66;
    int cfgM = `PAX_CFG_RESET;
    int pdfL = 0;
    int pageL = 0;
    int r;
    logic [15:0] rd;
    always #5 clk = ~clk;
    pax_regs #(.SMR_CYCLES(8)) u_pax_regs (.clk(clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .anStatus(anStatus), .dpCtl(dpCtl));
    pax_mgmt_model u_pax_mgmt_model (.clk(clk), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));
    function automatic logic [10:0] exp_dp(input int c);
        return {c[15] | c[13], c[14] | c[13], c[13], anStatus.signalDetector | c[12], c[10],
            anStatus.lineLink100 | c[7], c[4], c[2], c[1], c[0], 1'b0};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
        int m;
        u_pax_mgmt_model.access(1'b1, a, d, be, rd);
        m = `PAX_CFG_WMASK & 16'hf69f & {{8{be[1]}}, {8{be[0]}}};
        if (a == 8'h40) cfgM = (cfgM & ~m) | (d & m);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] e);
        u_pax_mgmt_model.access(1'b0, a, 16'h0000, 2'b11, rd);
        chk(nm, {16'h0000, e}, {16'h0000, rd});
    endtask
    task automatic rd_exp;
        int e;
        e = pdfL * 16 + anStatus.partnerNextPage * 8 + pageL * 2 + anStatus.partnerAutoneg;
        rdc("expansion", 8'h18, e[15:0]);
        pageL = 0;
        pdfL = anStatus.parDetectFault;
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk);
        num_errors++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rdc("config reset", 8'h40, `PAX_CFG_RESET);
        rd_exp();
        $display("test defaults done");
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            anStatus.signalDetector <= r[20];
            anStatus.lineLink100 <= r[21];
            wr(8'h40, r[15:0] & 16'hfff5, r[17:16]);
            @(posedge clk);
            #1 chk("dpctl", {21'h0, exp_dp(cfgM)}, {21'h0, dpCtl});
            rdc("config", 8'h40, cfgM[15:0]);
        end
        $display("test config done");
        wr(8'h44, 16'hffff, 2'b11);
        rdc("unmapped", 8'h44, 16'h0000);
        wr(8'h18, 16'hffff, 2'b11);
        rd_exp();
        $display("test refusals done");
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            anStatus.partnerNextPage <= r[0];
            anStatus.partnerAutoneg <= r[1];
            anStatus.parDetectFault <= r[2];
            anStatus.pageReceived <= r[3];
            pdfL = pdfL | r[2] | r[4];
            pageL = pageL | r[3];
            @(posedge clk);
            anStatus.pageReceived <= 1'b0;
            anStatus.parDetectFault <= r[4];
            repeat (2) @(posedge clk);
            rd_exp();
        end
        rd_exp();
        $display("test expansion done");
        wr(8'h40, cfgM[15:0] | 16'h0008, 2'b01);
        rdc("reset busy", 8'h40, cfgM[15:0] | 16'h0008);
        wr(8'h40, cfgM[15:0] | 16'h0008, 2'b01);
        rdc("reset restart", 8'h40, cfgM[15:0] | 16'h0008);
        repeat (12) @(posedge clk);
        rdc("reset clear", 8'h40, cfgM[15:0]);
        wr(8'h40, cfgM[15:0] | 16'h0002, 2'b01);
        @(posedge clk);
        #1 chk("sleep", {21'h0, exp_dp(cfgM)}, {21'h0, dpCtl});
        wr(8'h40, cfgM[15:0] & 16'hfffd, 2'b01);
        rdc("wake", 8'h40, cfgM[15:0] | 16'h0008);
        $display("test sequencer done");
        close_out();
    end
endmodule
